// ==== design/crsup_pkg.sv ====
package crsup_pkg;

  // start-up interval on the internal oscillator
  localparam int unsigned START_CYCLES     = 1024;
  // reset stretch after the reset input returns high
  localparam int unsigned RST_TIMER_CYCLES = 4096;
  // reset input low-time filter
  localparam int unsigned CLK_HZ           = 20_000_000;
  localparam int unsigned RST_FILT_NS      = 1000;
  localparam int unsigned RST_FILT_CYCLES  =
    (RST_FILT_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  // watchdog timeout default
  localparam int unsigned WDOG_CYCLES      = 65536;
  // external clock loss detection window, in system cycles
  localparam int unsigned XLOSS_CYCLES     = 8;
  // reset values
  localparam logic [23:0] BOOT_ADDR        = 24'h00_0000;

  typedef enum logic [1:0] {
    CRSUP_IF_SPI,
    CRSUP_IF_UART,
    CRSUP_IF_I2C
  } crsup_iface_type;

  typedef enum logic [1:0] {
    CRSUP_CK_START,
    CRSUP_CK_INT,
    CRSUP_CK_EXT
  } crsup_clk_type;

  typedef struct packed {
    logic iface_sel_a;
    logic iface_sel_b;
    logic [1:0] addr;
  } crsup_strap_type;

  typedef struct packed {
    crsup_iface_type iface;
    logic [1:0]      addr;
  } crsup_cfg_type;

endpackage

// ==== design/crsup_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module crsup_top #(
  parameter int unsigned RST_TIMER = crsup_pkg::RST_TIMER_CYCLES,
  parameter int unsigned WDOG_TMO  = crsup_pkg::WDOG_CYCLES
) (
  // clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      sys_rst,
  // supply and reset pin
  input  wire logic                      por_ok,
  input  wire logic                      reset_n_pin,
  // oscillator
  input  wire logic                      ext_clk_alive,
  // processor side
  input  wire logic                      wdog_refresh,
  // straps
  input  wire crsup_pkg::crsup_strap_type strap_in,
  // outputs
  output var  logic                      core_rst,
  output var  logic [23:0]               fetch_addr,
  output var  logic                      clk_sel_ext,
  output var  logic                      ext_fail_stat,
  output var  crsup_pkg::crsup_cfg_type  cfg_out
);
  import crsup_pkg::*;

  // counter widths fixed at 16 and 24 bits
  if (RST_TIMER < 2 || RST_TIMER > 65535 ||
      WDOG_TMO < 2 || WDOG_TMO > 65535 * 256) begin
    $error("crsup_top: unsupported counter parameter");
  end

  typedef struct packed {
    logic            rst_s1;
    logic            rst_s2;
    logic [7:0]      filt_cnt;
    logic            ext_req;
    logic [15:0]     rst_cnt;
    logic            core_rst;
    logic [23:0]     wdog_cnt;
    logic            wdog_tmo;
    crsup_clk_type   ck_state;
    logic [10:0]     start_cnt;
    logic [3:0]      loss_cnt;
    logic            sel_ext;
    logic            ext_fail;
    crsup_cfg_type   cfg;
  } crsup_state_type;

  crsup_state_type state_reg;
  crsup_state_type state_next;

  function automatic crsup_iface_type decode_iface(input crsup_strap_type s);
    if (!s.iface_sel_a) begin
      decode_iface = CRSUP_IF_SPI;
    end else if (s.iface_sel_b) begin
      decode_iface = CRSUP_IF_I2C;
    end else begin
      decode_iface = CRSUP_IF_UART;
    end
  endfunction

  logic rst_any;
  assign rst_any = !por_ok || state_reg.ext_req || state_reg.wdog_tmo;

  always_comb begin
    state_next = state_reg;
    // synchroniser, first stage read only by second
    state_next.rst_s1 = reset_n_pin;
    state_next.rst_s2 = state_reg.rst_s1;
    // low-time filter; active low input
    if (!state_reg.rst_s2) begin
      if (state_reg.filt_cnt >= 8'(RST_FILT_CYCLES - 1)) begin
        state_next.ext_req = 1'b1;
      end else begin
        state_next.filt_cnt = state_reg.filt_cnt + 8'h01;
      end
    end else begin
      state_next.filt_cnt = 8'h00;
      state_next.ext_req  = 1'b0;
    end
    // reset timer
    if (rst_any) begin
      state_next.core_rst = 1'b1;
      state_next.rst_cnt  = 16'h0000;
    end else if (state_reg.core_rst) begin
      if (state_reg.rst_cnt == 16'(RST_TIMER - 1)) begin
        state_next.core_rst = 1'b0;
      end else begin
        state_next.rst_cnt = state_reg.rst_cnt + 16'h0001;
      end
    end
    // straps latched while reset is in force
    if (state_reg.core_rst) begin
      state_next.cfg.iface = decode_iface(strap_in);
      state_next.cfg.addr  = strap_in.addr;
    end
    // watchdog, halted in reset
    state_next.wdog_tmo = 1'b0;
    if (state_reg.core_rst || wdog_refresh) begin
      state_next.wdog_cnt = 24'h00_0000;
    end else if (state_reg.wdog_cnt == 24'(WDOG_TMO - 1)) begin
      state_next.wdog_tmo = 1'b1;
      state_next.wdog_cnt = 24'h00_0000;
    end else begin
      state_next.wdog_cnt = state_reg.wdog_cnt + 24'h00_0001;
    end
    // external clock loss monitor
    if (ext_clk_alive) begin
      state_next.loss_cnt = 4'h0;
    end else if (state_reg.loss_cnt != 4'(XLOSS_CYCLES)) begin
      state_next.loss_cnt = state_reg.loss_cnt + 4'h1;
    end
    // clock selector; keeps running through reset input
    case (state_reg.ck_state)
      CRSUP_CK_START: begin
        state_next.sel_ext = 1'b0;
        if (state_reg.start_cnt == 11'(START_CYCLES - 1)) begin
          state_next.ck_state = CRSUP_CK_INT;
        end else begin
          state_next.start_cnt = state_reg.start_cnt + 11'h001;
        end
      end
      CRSUP_CK_INT: begin
        state_next.sel_ext = 1'b0;
        if (ext_clk_alive && state_reg.loss_cnt == 4'h0) begin
          state_next.ck_state = CRSUP_CK_EXT;
          state_next.sel_ext  = 1'b1;
        end
      end
      CRSUP_CK_EXT: begin
        if (state_reg.loss_cnt == 4'(XLOSS_CYCLES)) begin
          state_next.ck_state = CRSUP_CK_INT;
          state_next.sel_ext  = 1'b0;
          state_next.ext_fail = 1'b1;
        end
      end
      default: begin
        state_next.ck_state = CRSUP_CK_START;
      end
    endcase
    // failure flag cleared on new start of external clock
    if (state_reg.ck_state == CRSUP_CK_INT && state_next.ck_state == CRSUP_CK_EXT) begin
      state_next.ext_fail = 1'b0;
    end
    // power-on restarts the start-up interval
    if (!por_ok) begin
      state_next.ck_state  = CRSUP_CK_START;
      state_next.start_cnt = 11'h000;
      state_next.sel_ext   = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg           <= '0;
      state_reg.rst_s1    <= 1'b1;
      state_reg.rst_s2    <= 1'b1;
      state_reg.core_rst  <= 1'b1;
      state_reg.ck_state  <= CRSUP_CK_START;
      state_reg.cfg.iface <= CRSUP_IF_SPI;
    end else begin
      state_reg <= state_next;
    end
  end

  // clock select changes only on a registered, single-cycle decision
  assign clk_sel_ext   = state_reg.sel_ext;
  assign core_rst      = state_reg.core_rst;
  assign ext_fail_stat = state_reg.ext_fail;
  assign cfg_out       = state_reg.cfg;
  assign fetch_addr    = BOOT_ADDR;

  // assertions
  a_start_internal: assert property (@(posedge sys_clk) disable iff (sys_rst)
    state_reg.ck_state == CRSUP_CK_START |-> !clk_sel_ext)
    else $error("external clock selected during start-up");
  a_switch_ext: assert property (@(posedge sys_clk) disable iff (sys_rst)
    state_reg.ck_state == CRSUP_CK_INT && ext_clk_alive && state_reg.loss_cnt == 4'h0 && por_ok
    |=> clk_sel_ext)
    else $error("no switch to external clock");
  a_fall_back: assert property (@(posedge sys_clk) disable iff (sys_rst)
    clk_sel_ext && state_reg.loss_cnt == 4'(XLOSS_CYCLES) |=> !clk_sel_ext && ext_fail_stat)
    else $error("no fallback on clock loss");
  a_por_reset: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !por_ok |=> core_rst)
    else $error("supply low without reset");
  a_filter_short: assert property (@(posedge sys_clk) disable iff (sys_rst)
    state_reg.ext_req |-> $past(!state_reg.rst_s2, 1) && $past(!state_reg.rst_s2, 2) &&
    $past(!state_reg.rst_s2, RST_FILT_CYCLES))
    else $error("reset input accepted too early");
  a_hold_timer: assert property (@(posedge sys_clk) disable iff (sys_rst)
    $fell(core_rst) |-> state_reg.rst_cnt == 16'(RST_TIMER - 1) && !state_reg.ext_req)
    else $error("reset released early");
  a_wdog_reset: assert property (@(posedge sys_clk) disable iff (sys_rst)
    state_reg.wdog_tmo |=> core_rst)
    else $error("watchdog timeout without reset");
  a_strap_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !core_rst && !$past(core_rst) |-> $stable(cfg_out))
    else $error("straps changed outside reset");
  a_spi_strap: assert property (@(posedge sys_clk) disable iff (sys_rst)
    core_rst && !strap_in.iface_sel_a |=> cfg_out.iface == CRSUP_IF_SPI)
    else $error("strap a low not SPI");

  c_switch_ext: cover property (@(posedge sys_clk) disable iff (sys_rst) $rose(clk_sel_ext));
  c_fall_back:  cover property (@(posedge sys_clk) disable iff (sys_rst) $rose(ext_fail_stat));
  c_release:    cover property (@(posedge sys_clk) disable iff (sys_rst) $fell(core_rst));
  c_wdog:       cover property (@(posedge sys_clk) disable iff (sys_rst) state_reg.wdog_tmo);

endmodule
`default_nettype wire

// ==== verif/crsup_far.sv ====
`timescale 1ns/10ps
`default_nettype none
module crsup_far (
  // clock
  input  wire logic                       sys_clk,
  // bench commands
  input  wire logic                       xtal_en,
  input  wire logic [7:0]                 low_len,
  input  wire logic                       low_go,
  input  wire crsup_pkg::crsup_strap_type strap_set,
  // device pins
  output var  logic                       ext_clk_alive,
  output var  logic                       reset_n_pin,
  output var  crsup_pkg::crsup_strap_type strap_in
);
  import crsup_pkg::*;
  logic [7:0] start_reg = 8'h00;
  logic [7:0] low_reg   = 8'h00;
  always_ff @(posedge sys_clk) begin
    start_reg <= !xtal_en ? 8'h00 : (start_reg == 8'h28) ? start_reg : start_reg + 8'h01;
    low_reg   <= low_go ? low_len : (low_reg != 8'h00) ? low_reg - 8'h01 : 8'h00;
  end
  // crystal needs 40 cycles before the detector reports it
  assign ext_clk_alive = (start_reg == 8'h28);
  assign reset_n_pin   = (low_reg == 8'h00);
  assign strap_in      = strap_set;
endmodule
`default_nettype wire

// ==== verif/crsup_top_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module crsup_top_tb;
  import crsup_pkg::*;
  localparam int unsigned RT = 16;
  localparam int unsigned WT = 64;
  logic sys_clk = 0, sys_rst = 1, por_ok = 1, wdog_refresh = 0;
  logic xtal_en = 1, low_go = 0, ref_en = 1, ext_clk_alive, reset_n_pin;
  logic core_rst, clk_sel_ext, ext_fail_stat;
  logic [7:0] low_len = 8'h00;
  logic [23:0] fetch_addr;
  crsup_strap_type strap_set = '0, strap_in;
  crsup_cfg_type cfg_out;
  int miscompares = 0, cmp_count = 0, rc = 0;
  crsup_far FAR (.sys_clk(sys_clk), .xtal_en(xtal_en), .low_len(low_len), .low_go(low_go),
    .strap_set(strap_set), .ext_clk_alive(ext_clk_alive), .reset_n_pin(reset_n_pin),
    .strap_in(strap_in));
  crsup_top #(.RST_TIMER(RT), .WDOG_TMO(WT)) DUT (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .por_ok(por_ok), .reset_n_pin(reset_n_pin), .ext_clk_alive(ext_clk_alive),
    .wdog_refresh(wdog_refresh), .strap_in(strap_in), .core_rst(core_rst),
    .fetch_addr(fetch_addr), .clk_sel_ext(clk_sel_ext), .ext_fail_stat(ext_fail_stat),
    .cfg_out(cfg_out));
  initial forever #25 sys_clk = ~sys_clk;
  // software-style periodic refresh
  always @(posedge sys_clk) begin
    rc <= (rc + 1) % 16;
    wdog_refresh <= ref_en && rc == 0;
  end
  task automatic tick(input int n = 1);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  function automatic logic sig(input int s);
    return s == 0 ? core_rst : s == 1 ? clk_sel_ext : ext_fail_stat;
  endfunction
  task automatic wt(input int s, input logic v, input int lim, output int n);
    n = 0;
    while (sig(s) !== v && n < lim) begin
      tick();
      n++;
    end
  endtask
  task automatic pulse(input int len);
    @(posedge sys_clk) begin
      low_len <= len[7:0];
      low_go <= 1;
    end
    @(posedge sys_clk) low_go <= 0;
    tick();
  endtask
  task automatic t_boot;
    int n1, n2;
    chk(core_rst === 1'b1 && fetch_addr === 24'h00_0000, "boot reset");
    wt(0, 0, RT + 8, n1);
    chk(n1 >= RT && n1 < RT + 8, "boot reset length");
    wt(1, 1, 1100, n2);
    chk(n1 + n2 >= 1022 && n1 + n2 <= 1030, "start interval");
  endtask
  task automatic t_fail;
    int n;
    @(posedge sys_clk) xtal_en <= 0;
    tick();
    wt(1, 0, 20, n);
    chk(n >= 6 && n <= 11 && ext_fail_stat === 1'b1, "fallback");
    @(posedge sys_clk) xtal_en <= 1;
    tick();
    wt(1, 1, 60, n);
    chk(n >= 38 && n <= 45 && ext_fail_stat === 1'b0, "reselect");
  endtask
  task automatic t_pin;
    int n1, n2;
    pulse(18);
    wt(0, 1, 40, n1);
    chk(n1 == 40, "short pulse ignored");
    pulse(60);
    wt(0, 1, 40, n1);
    chk(n1 >= 20 && n1 <= 26 && clk_sel_ext === 1'b1, "long pulse");
    wt(0, 0, 120, n2);
    chk(n2 >= 60 - n1 + RT && n2 <= 60 - n1 + RT + 6, "release");
  endtask
  task automatic t_wdog;
    int n;
    wt(0, 1, 200, n);
    chk(n == 200, "refreshed no reset");
    @(posedge sys_clk) ref_en <= 0;
    wt(0, 1, WT + 8, n);
    chk(n >= WT - 18 && n <= WT + 4, "watchdog reset");
    @(posedge sys_clk) ref_en <= 1;
    wt(0, 0, RT + 8, n);
    chk(core_rst === 1'b0, "watchdog release");
  endtask
  task automatic t_strap;
    crsup_strap_type st[3];
    crsup_cfg_type ex;
    int n;
    st = '{4'b0001, 4'b1010, 4'b1111};
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk) strap_set <= st[i];
      pulse(30);
      wt(0, 1, 40, n);
      wt(0, 0, 120, n);
      @(posedge sys_clk) strap_set <= ~st[i];
      tick(3);
      ex.iface = !st[i].iface_sel_a ? CRSUP_IF_SPI : st[i].iface_sel_b ? CRSUP_IF_I2C
                                                                      : CRSUP_IF_UART;
      ex.addr = st[i].addr;
      chk(cfg_out === ex, "strap config");
    end
  endtask
  task automatic t_por;
    int n;
    @(posedge sys_clk) por_ok <= 0;
    tick(2);
    chk(core_rst === 1'b1 && clk_sel_ext === 1'b0, "supply low");
    @(posedge sys_clk) por_ok <= 1;
    wt(1, 1, 1100, n);
    chk(n >= 1015 && n <= 1030 && core_rst === 1'b0, "supply back");
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge sys_clk);
    sys_rst <= 0;
    tick();
    t_boot();
    t_fail();
    t_pin();
    t_wdog();
    t_strap();
    t_por();
    close_out();
  end
  initial begin
    #400_000;
    miscompares++;
    close_out();
  end
endmodule
`default_nettype wire
